/* File: irq_request_monitor_bank_test.sv */
// self-checking bench of the request monitor bank
// assumes irqmon_bank, irqmon_src_model and irqmon_pkg compiled before it
`timescale 1ns/1ns
`default_nettype none
module irq_request_monitor_bank_test;
  typedef struct packed {
    logic [37:0]      src;
    logic [5:0][31:0] exp;
  } irqmon_row_s;
  logic        clk;
  logic        rst;
  logic [37:0] pattern;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  routing;
  irqmon_pkg::irqmon_src_s src_req;
  irqmon_row_s rows [3];
  int          miscompares;
  int          check_count;

  irqmon_src_model MODEL (.clk(clk), .pattern(pattern), .src_req(src_req));
  irqmon_bank DUT (
    .clk(clk), .rst(rst), .src_req(src_req),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .dma_request_routing_select(routing)
  );

  // **********************************************
  // clock, watchdog and helpers
  // **********************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // read: hold ar until taken, keep rready up until rvalid is seen
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    while (!rvalid) @(negedge clk);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask

  // write: offer aw and w together, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    bready  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge clk);
      if (ta) begin
        awvalid <= 1'b0;
        da = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge clk); while (!bvalid);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask

  // **********************************************
  // tests
  // **********************************************
  initial begin
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    pattern = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    // rows: request levels, then expected vector54 down to vector49
    rows[0] = '{38'h15_5555_5555, {32'h55, 32'h55, 32'h15, 32'h2A, 32'h0A, 32'h25}};
    rows[1] = '{38'h2A_AAAA_AAAA, {32'hAA, 32'h2A, 32'h2A, 32'h15, 32'h15, 32'h52}};
    rows[2] = '{38'h3F_FFFF_FFFF, {32'hFF, 32'h7F, 32'h3F, 32'h3F, 32'h1F, 32'h77}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4));
      chk("monitor after reset", d, 32'h0);
    end
    foreach (rows[k]) begin
      pattern <= rows[k].src;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
        rd(8'(i * 4));
        chk("monitor word", d, rows[k].exp[i]);
        chk("monitor resp", {30'h0, r}, 32'h0);
      end
    end
    // routing two usb port0 endpoints to dma hides only their bits
    wr(8'h18, 32'h0000_0005);
    chk("routing write resp", {30'h0, r}, 32'h0);
    chk("routing select", {27'h0, routing}, 32'h05);
    rd(8'h04);
    chk("vector50 routed", d, 32'h1A);
    rd(8'h0C);
    chk("vector52 unrouted", d, 32'h3F);
    // monitors ignore writes and reads leave requests alone
    wr(8'h14, 32'h0000_0000);
    chk("monitor write resp", {30'h0, r}, 32'h0);
    rd(8'h14);
    chk("vector54 after write", d, 32'hFF);
    rd(8'h14);
    chk("vector54 reread", d, 32'hFF);
    pattern <= '0;
    repeat (3) @(posedge clk);
    rd(8'h00);
    chk("vector49 released", d, 32'h0);
    // unmapped place
    rd(8'h1C);
    chk("unmapped data", d, 32'h0);
    chk("unmapped read resp", {30'h0, r}, 32'h2);
    wr(8'h20, 32'hFFFF_FFFF);
    chk("unmapped write resp", {30'h0, r}, 32'h2);
    // reset in mid-run clears routing
    pattern <= rows[2].src;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("routing after reset", {27'h0, routing}, 32'h0);
    rd(8'h04);
    chk("vector50 after reset", d, 32'h1F);
    // routing byte not strobed leaves the routing select alone
    wstrb <= 4'hE;
    wr(8'h18, 32'h0000_001F);
    wstrb <= 4'hF;
    chk("routing strobe off resp", {30'h0, r}, 32'h0);
    chk("routing strobe off", {27'h0, routing}, 32'h0);
    rd(8'h04);
    chk("vector50 strobe off", d, 32'h1F);
    end_of_test();
  end
endmodule // irq_request_monitor_bank_test
`default_nettype wire

/* File: irqmon_bank.sv */
// request monitor bank: six read-only per-vector request monitors behind an axi4-lite slave
// assumes request lines synchronous to clk, one outstanding read and one write at a time
//
// Summary of operation
// - vector49 monitor shows all requests of vector 49 in one read.
// - unassigned monitor bits are reserved and read zero.
// - vector49 bits 6..4 serial status, transmit, receive; bit 3 reads zero.
// - vector49 bit 2 follows mac1 power management request.
// - vector49 bit 1 follows mac1 system bus request.
// - vector49 bit 0 follows can1 request.
// - vector50 monitor shows all requests of vector 50.
// - vector50 bits 4..0 show usb port0 endpoint 5..1 data requests.
// - usb port0 endpoint routed to dma reads zero in its bit.
// - vector51 monitor shows all requests of vector 51.
// - vector51 bits 5..2 show usb port0 grouped status requests.
// - vector51 bit 1 ep0 out, bit 0 ep0 in of usb port0.
// - vector52 monitor shows all requests of vector 52.
// - vector52 bit 5 follows remote receiver 0 request.
// - vector52 bits 4..0 show usb port1 endpoint 5..1 data requests.
// - vector53 monitor shows all requests of vector 53.
// - vector53 bit 6 follows remote receiver 1 request.
// - vector53 bits 5..2 usb port1 status, bit 1 ep0 out, bit 0 ep0 in.
// - vector54 monitor shows all requests of vector 54.
// - vector54 bit n follows dma channel n request.
// - monitor bits are read-only, one when pending, zero after reset.
`include "irqmon_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module irqmon_bank (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire irqmon_pkg::irqmon_src_s src_req,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic [4:0]                  dma_request_routing_select
);

  // ****************************************
  // monitor capture
  // ****************************************
  irqmon_pkg::irqmon_word_t mon_reg [6];
  irqmon_pkg::irqmon_word_t mon_next [6];
  logic [4:0]               route_reg;
  logic [4:0]               usb0_drq_cpu;

  assign dma_request_routing_select = route_reg;
  // endpoints steered to the dma controller are hidden from the cpu
  assign usb0_drq_cpu = src_req.usb_port0_requests.ep_data_request & ~route_reg;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      mon_next[i] = `IRQMON_MON_RST;
    end
    mon_next[0][`IRQMON_V49_MFS_LSB +: 3] = src_req.serial_channel_requests;
    mon_next[0][`IRQMON_V49_PMI]          = src_req.mac1_power_mgmt_request;
    mon_next[0][`IRQMON_V49_SBD]          = src_req.mac1_system_bus_request;
    mon_next[0][`IRQMON_V49_CAN]          = src_req.can1_request;
    mon_next[1][4:0]                      = usb0_drq_cpu;
    mon_next[2][`IRQMON_STAT_LSB +: 4]    = src_req.usb_port0_requests.grouped_status;
    mon_next[2][`IRQMON_EP0_OUT]          = src_req.usb_port0_requests.ep0_out_data_request;
    mon_next[2][`IRQMON_EP0_IN]           = src_req.usb_port0_requests.ep0_in_data_request;
    mon_next[3][`IRQMON_V52_RC0]          = src_req.remote_rx0_request;
    mon_next[3][4:0]                      = src_req.usb_port1_requests.ep_data_request;
    mon_next[4][`IRQMON_V53_RC1]          = src_req.remote_rx1_request;
    mon_next[4][`IRQMON_STAT_LSB +: 4]    = src_req.usb_port1_requests.grouped_status;
    mon_next[4][`IRQMON_EP0_OUT]          = src_req.usb_port1_requests.ep0_out_data_request;
    mon_next[4][`IRQMON_EP0_IN]           = src_req.usb_port1_requests.ep0_in_data_request;
    mon_next[5][7:0]                      = src_req.dma_channel_requests;
  end

  // monitors follow the live lines every cycle, reads never touch them
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (rst) begin
        mon_reg[i] <= `IRQMON_MON_RST;
      end else begin
        mon_reg[i] <= mon_next[i];
      end
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  irqmon_pkg::irqmon_wr_e wr_state;
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   wr_fire;
  logic                   wr_hit;

  assign s_axi_awready = (wr_state == irqmon_pkg::IRQMON_WR_IDLE) && !aw_held;
  assign s_axi_wready  = (wr_state == irqmon_pkg::IRQMON_WR_IDLE) && !w_held;
  assign wr_fire = (wr_state == irqmon_pkg::IRQMON_WR_IDLE) && aw_held && w_held;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held     <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held     <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held     <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held     <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // monitors accept writes silently; unmapped addresses answer slverr
  always_comb begin
    if (aw_addr_reg[7:2] == `IRQMON_ROUTE_OFS >> 2) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg[7:2] <= `IRQMON_V54_OFS >> 2) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      route_reg <= `IRQMON_ROUTE_RST;
    end else if (wr_fire && aw_addr_reg[7:2] == `IRQMON_ROUTE_OFS >> 2 && w_strb_reg[0]) begin
      route_reg <= w_data_reg[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state    <= irqmon_pkg::IRQMON_WR_IDLE;
      s_axi_bresp <= `IRQMON_RESP_OKAY;
    end else begin
      case (wr_state)
        irqmon_pkg::IRQMON_WR_IDLE: begin
          if (wr_fire) begin
            wr_state    <= irqmon_pkg::IRQMON_WR_RESP;
            s_axi_bresp <= wr_hit ? `IRQMON_RESP_OKAY : `IRQMON_RESP_SLV;
          end
        end
        irqmon_pkg::IRQMON_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state <= irqmon_pkg::IRQMON_WR_IDLE;
          end
        end
        default: begin
          wr_state <= irqmon_pkg::IRQMON_WR_IDLE;
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state == irqmon_pkg::IRQMON_WR_RESP);

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  irqmon_pkg::irqmon_rd_e rd_state;
  logic [31:0]            rd_word;
  logic [1:0]             rd_resp;

  assign s_axi_arready = (rd_state == irqmon_pkg::IRQMON_RD_IDLE);
  assign s_axi_rvalid  = (rd_state == irqmon_pkg::IRQMON_RD_DATA);

  always_comb begin
    rd_resp = `IRQMON_RESP_OKAY;
    if (s_axi_araddr[7:2] == `IRQMON_ROUTE_OFS >> 2) begin
      rd_word = {27'h0, route_reg};
    end else if (s_axi_araddr[7:2] <= `IRQMON_V54_OFS >> 2) begin
      rd_word = mon_reg[s_axi_araddr[4:2]];
    end else begin
      rd_word = 32'h0000_0000;
      rd_resp = `IRQMON_RESP_SLV;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_state    <= irqmon_pkg::IRQMON_RD_IDLE;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IRQMON_RESP_OKAY;
    end else begin
      case (rd_state)
        irqmon_pkg::IRQMON_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state    <= irqmon_pkg::IRQMON_RD_DATA;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
          end
        end
        irqmon_pkg::IRQMON_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state <= irqmon_pkg::IRQMON_RD_IDLE;
          end
        end
        default: begin
          rd_state <= irqmon_pkg::IRQMON_RD_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_v49_serial_map: assert property (1'b1 |=> mon_reg[0][6:4] == $past(src_req.serial_channel_requests))
    else $error("vector49 serial bits wrong");
  a_v49_resv_zero: assert property (mon_reg[0][31:7] == 25'h0 && !mon_reg[0][3])
    else $error("vector49 reserved bits set");
  a_v49_pmi_bit: assert property (src_req.mac1_power_mgmt_request |=> mon_reg[0][2])
    else $error("pmi bit not set");
  a_v49_sbd_bit: assert property (!src_req.mac1_system_bus_request |=> !mon_reg[0][1])
    else $error("sbd bit stuck");
  a_v49_can_bit: assert property (1'b1 |=> mon_reg[0][0] == $past(src_req.can1_request))
    else $error("can bit wrong");
  a_v50_drq_route: assert property (1'b1 |=> mon_reg[1][4:0] ==
      ($past(src_req.usb_port0_requests.ep_data_request) & ~$past(route_reg)))
    else $error("usb0 drq bits wrong");
  a_v50_dma_hidden: assert property (route_reg[0] |=> !mon_reg[1][0])
    else $error("routed endpoint visible");
  a_v51_usb0_stat: assert property (1'b1 |=> mon_reg[2][5:0] == {$past(src_req.usb_port0_requests.grouped_status),
      $past(src_req.usb_port0_requests.ep0_out_data_request),
      $past(src_req.usb_port0_requests.ep0_in_data_request)})
    else $error("vector51 bits wrong");
  a_v52_rx0_usb1: assert property (1'b1 |=> mon_reg[3][5:0] ==
      {$past(src_req.remote_rx0_request), $past(src_req.usb_port1_requests.ep_data_request)})
    else $error("vector52 bits wrong");
  a_v53_rx1_usb1: assert property (1'b1 |=> mon_reg[4][6:0] == {$past(src_req.remote_rx1_request),
      $past(src_req.usb_port1_requests.grouped_status),
      $past(src_req.usb_port1_requests.ep0_out_data_request),
      $past(src_req.usb_port1_requests.ep0_in_data_request)})
    else $error("vector53 bits wrong");
  a_v54_dma_map: assert property (1'b1 |=> mon_reg[5][7:0] == $past(src_req.dma_channel_requests))
    else $error("vector54 bits wrong");
  a_mon_resv_zero: assert property (mon_reg[1][31:5] == 27'h0 && mon_reg[2][31:6] == 26'h0 &&
      mon_reg[3][31:6] == 26'h0 && mon_reg[4][31:7] == 25'h0 && mon_reg[5][31:8] == 24'h0)
    else $error("reserved monitor bits set");
  a_mon_reset_zero: assert property (disable iff (1'b0) $past(rst) |-> mon_reg[5] == 32'h0 && mon_reg[0] == 32'h0)
    else $error("monitor not cleared by reset");
  a_read_no_clear: assert property (s_axi_arvalid && s_axi_arready && src_req.can1_request ##1
      src_req.can1_request |=> mon_reg[0][0])
    else $error("read cleared a request");
  a_read_data_match: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `IRQMON_V54_OFS |=>
      s_axi_rvalid && s_axi_rdata == $past(mon_reg[5]))
    else $error("read data not the monitor");
  a_mon_write_ignored: assert property (wr_fire && aw_addr_reg == `IRQMON_V54_OFS |=>
      mon_reg[5] == $past(mon_next[5]))
    else $error("monitor took a write");

  c_read_pending: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h0);
  c_route_hides: cover property (route_reg != 5'h0 && src_req.usb_port0_requests.ep_data_request != 5'h0);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `IRQMON_RESP_OKAY);
  c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == `IRQMON_RESP_SLV);

endmodule // irqmon_bank
`default_nettype wire

/* File: irqmon_defs.svh */
// register offsets, field positions and reset values of the request monitor bank
// assumes inclusion by the bank module
`ifndef IRQMON_DEFS_SVH
`define IRQMON_DEFS_SVH
`define IRQMON_V49_OFS    8'h00
`define IRQMON_V50_OFS    8'h04
`define IRQMON_V51_OFS    8'h08
`define IRQMON_V52_OFS    8'h0C
`define IRQMON_V53_OFS    8'h10
`define IRQMON_V54_OFS    8'h14
`define IRQMON_ROUTE_OFS  8'h18
`define IRQMON_ROUTE_RST  5'h00
`define IRQMON_MON_RST    32'h0000_0000
`define IRQMON_RESP_OKAY  2'h0
`define IRQMON_RESP_SLV   2'h2
`define IRQMON_V49_MFS_LSB 4
`define IRQMON_V49_PMI    2
`define IRQMON_V49_SBD    1
`define IRQMON_V49_CAN    0
`define IRQMON_STAT_LSB   2
`define IRQMON_EP0_OUT    1
`define IRQMON_EP0_IN     0
`define IRQMON_V52_RC0    5
`define IRQMON_V53_RC1    6
`endif

/* File: irqmon_pkg.sv */
// types shared by the request monitor bank
// assumes irqmon_defs.svh on the include path
package irqmon_pkg;
  // one usb function controller: endpoint 5..1 drq, grouped status 3..0, ep0 out/in
  typedef struct packed {
    logic [4:0] ep_data_request;
    logic [3:0] grouped_status;
    logic       ep0_out_data_request;
    logic       ep0_in_data_request;
  } irqmon_usb_s;
  typedef struct packed {
    logic [2:0]  serial_channel_requests;
    logic        mac1_power_mgmt_request;
    logic        mac1_system_bus_request;
    logic        can1_request;
    irqmon_usb_s usb_port0_requests;
    irqmon_usb_s usb_port1_requests;
    logic        remote_rx0_request;
    logic        remote_rx1_request;
    logic [7:0]  dma_channel_requests;
  } irqmon_src_s;
  typedef enum logic [1:0] {
    IRQMON_WR_IDLE = 2'h0,
    IRQMON_WR_RESP = 2'h1
  } irqmon_wr_e;
  typedef enum logic [1:0] {
    IRQMON_RD_IDLE = 2'h0,
    IRQMON_RD_DATA = 2'h1
  } irqmon_rd_e;
  typedef logic [31:0] irqmon_word_t;
endpackage

/* File: irqmon_src_model.sv */
// partner model: the peripheral request sources that feed the monitor bank
// assumes the bench sets the wanted request levels on pattern, one bit per line
`timescale 1ns/1ns
`default_nettype none
module irqmon_src_model (
  input  wire logic                   clk,
  input  wire logic [37:0]            pattern,
  output var irqmon_pkg::irqmon_src_s src_req
);
  // **********************************************
  // request lines
  // **********************************************
  // levels move only just after an edge and then stand, like a real source
  always_ff @(posedge clk) begin
    src_req <= irqmon_pkg::irqmon_src_s'(pattern);
  end
endmodule // irqmon_src_model
`default_nettype wire
